/* File: hdl/serial_io_sync_async_channel.sv */
`timescale 1ns/1ps
// The external transfer clock runs its own domain; the frame engine lives
// in the system domain and sees that clock through a synchroniser, so
// external clock rates must stay well below a quarter of i_clock.
module serial_io_sync_async_channel #(
  parameter int CHANNEL = 1
) (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_transfer_clock_pin,
  input wire logic [1:0] i_mode,
  input wire logic [1:0] i_prescale,
  input wire logic i_ext_clock_sel,
  input wire logic i_clock_polarity,
  input wire logic i_msb_first,
  input wire logic [1:0] i_char_len,
  input wire logic i_parity_en,
  input wire logic i_parity_odd,
  input wire logic i_two_stop,
  input wire logic [7:0] i_brg,
  input wire logic i_handshake_disable,
  input wire logic i_handshake_rts_sel,
  input wire logic i_multi_clock_en,
  input wire logic i_alternate_clock_pin_select,
  input wire logic i_split_handshake_en,
  input wire logic i_open_drain,
  input wire logic i_continuous_rx,
  input wire logic i_data_invert,
  input wire logic i_tx_irq_on_done,
  input wire logic i_tx_enable,
  input wire logic i_rx_enable,
  input wire logic i_tx_write,
  input wire logic [8:0] i_tx_data,
  input wire logic i_rx_read,
  input wire logic i_serial_data_in,
  input wire logic i_handshake_pin,
  output logic o_serial_data_out,
  output logic o_serial_data_oe_n,
  output logic o_transfer_clock_pin,
  output logic o_transfer_clock_oe_n,
  output logic o_alt_clock_pin,
  output logic o_alt_clock_oe_n,
  output logic o_handshake_pin,
  output logic o_handshake_oe_n,
  output logic o_tx_buffer_empty,
  output logic o_tx_done,
  output logic [8:0] o_rx_data,
  output logic o_rx_full,
  output logic o_tx_irq,
  output logic o_rx_irq,
  output logic o_overrun_err,
  output logic o_framing_err,
  output logic o_parity_err,
  output logic o_error_sum,
  output logic o_config_err
);
  initial begin
    if (CHANNEL < 1 || CHANNEL > 3) begin
      $error("CHANNEL must be 1, 2 or 3");
    end
  end

  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_START = 5'h02,
    ST_DATA = 5'h04,
    ST_PARITY = 5'h08,
    ST_STOP = 5'h10
  } frame_t;

  // Link-side capture of the external transfer clock.
  logic ext_clk_r;
  always_ff @(posedge i_transfer_clock_pin or posedge i_rst) begin
    if (i_rst) begin
      ext_clk_r <= 1'b0;
    end else begin
      ext_clk_r <= ~ext_clk_r;
    end
  end

  // Toggle-based event crossing plus level synchronisers for the pins.
  logic ext_s1_r, ext_s2_r, ext_s3_r;
  logic ck_s1_r, ck_s2_r, ck_s3_r;
  logic rx_s1_r, rx_s2_r, cts_s1_r, cts_s2_r;
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      ext_s1_r <= 1'b0;
      ext_s2_r <= 1'b0;
      ext_s3_r <= 1'b0;
      ck_s1_r <= 1'b0;
      ck_s2_r <= 1'b0;
      ck_s3_r <= 1'b0;
      rx_s1_r <= 1'b1;
      rx_s2_r <= 1'b1;
      cts_s1_r <= 1'b1;
      cts_s2_r <= 1'b1;
    end else begin
      ext_s1_r <= ext_clk_r;
      ext_s2_r <= ext_s1_r;
      ext_s3_r <= ext_s2_r;
      ck_s1_r <= i_transfer_clock_pin;
      ck_s2_r <= ck_s1_r;
      ck_s3_r <= ck_s2_r;
      rx_s1_r <= i_serial_data_in;
      rx_s2_r <= rx_s1_r;
      cts_s1_r <= i_handshake_pin;
      cts_s2_r <= cts_s1_r;
    end
  end
  logic ext_tick;
  assign ext_tick = ext_s2_r ^ ext_s3_r;
  logic ck_rise, ck_fall;
  assign ck_rise = ck_s2_r & ~ck_s3_r;
  assign ck_fall = ~ck_s2_r & ck_s3_r;

  logic is_sync, is_async, ext_clk;
  assign is_sync = i_mode == sio_pkg::MODE_SYNC;
  assign is_async = i_mode == sio_pkg::MODE_ASYNC;
  // Third channel has no external clock
  assign ext_clk = i_ext_clock_sel && CHANNEL != 3;
  logic multi_ok;
  assign multi_ok = CHANNEL == 2 && i_multi_clock_en && !i_split_handshake_en;

  logic [4:0] pre_cnt_r;
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      pre_cnt_r <= 5'h00;
    end else begin
      pre_cnt_r <= pre_cnt_r + 5'h01;
    end
  end
  logic pre_tick;
  always_comb begin
    case (i_prescale)
      sio_pkg::PRE_DIV8:
        pre_tick = pre_cnt_r[2:0] == 3'(sio_pkg::PRE_DIV8_CNT - 1);
      sio_pkg::PRE_DIV32:
        pre_tick = pre_cnt_r == 5'(sio_pkg::PRE_DIV32_CNT - 1);
      default: pre_tick = 1'b1;
    endcase
  end
  logic src_tick;
  assign src_tick = ext_clk ? ext_tick : pre_tick;

  // Divide by n+1 with 8-bit n
  logic [7:0] brg_r;
  logic brg_tick;
  assign brg_tick = src_tick && brg_r == 8'h00;
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      brg_r <= sio_pkg::BRG_RESET;
    end else if (src_tick) begin
      brg_r <= (brg_r == 8'h00) ? i_brg : brg_r - 8'h01;
    end
  end

  // Internal sync clock: toggles each divided tick
  logic [3:0] os_r;
  logic sclk_r;
  logic int_edge;
  assign int_edge = brg_tick;

  logic [3:0] nbits;
  always_comb begin
    case (i_char_len)
      sio_pkg::LEN7: nbits = 4'h7;
      sio_pkg::LEN9: nbits = 4'h9;
      default: nbits = 4'h8;
    endcase
  end

  logic [8:0] tx_buf_r, tx_sh_r, rx_sh_r;
  logic tx_empty_r, tx_busy_r, started_r, rx_armed_r;
  logic [3:0] tx_cnt_r, rx_cnt_r;
  frame_t tx_st_r, rx_st_r;
  logic tx_par_r, rx_par_r, rx_stop2_r;
  logic txd_r, sync_busy_r;

  // Third channel inverts on buffer write
  logic [8:0] tx_wdata;
  assign tx_wdata = (CHANNEL == 3 && i_data_invert) ? ~i_tx_data : i_tx_data;

  logic cts_ok, tx_start;
  assign cts_ok = i_handshake_disable || i_handshake_rts_sel
                  || multi_ok || !cts_s2_r;
  assign tx_start = i_tx_enable && !tx_empty_r && !tx_busy_r && cts_ok
                    && (is_async || (is_sync && !sync_busy_r));

  // Bit selection for the two orders
  function automatic logic pick(input logic [8:0] d, input logic [3:0] i,
                                input logic msb, input logic [3:0] n);
    logic [3:0] k;
    k = msb ? 4'(n - 4'h1 - i) : i;
    pick = d[k];
  endfunction

  // Sync-mode shift and sample edges
  logic sh_edge, sm_edge;
  always_comb begin
    if (ext_clk) begin
      sh_edge = i_clock_polarity ? ck_rise : ck_fall;
      sm_edge = i_clock_polarity ? ck_fall : ck_rise;
    end else begin
      sh_edge = int_edge && (sclk_r == i_clock_polarity);
      sm_edge = int_edge && (sclk_r != i_clock_polarity);
    end
  end

  // Idle clock level is the inverse of polarity.
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      sclk_r <= 1'b1;
    end else if (!sync_busy_r) begin
      sclk_r <= ~i_clock_polarity;
    end else if (int_edge) begin
      sclk_r <= ~sclk_r;
    end
  end

  // Oversample counter for asynchronous bit timing
  logic bit_tick;
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      os_r <= 4'h0;
    end else if (brg_tick) begin
      os_r <= os_r + 4'h1;
    end
  end
  // Bit time is 16 divided ticks
  assign bit_tick = brg_tick && os_r == 4'(sio_pkg::OVERSAMPLE - 1);

  // Transmit side
  logic tx_load_ev, tx_done_ev;
  assign tx_load_ev = tx_start;
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      tx_buf_r <= sio_pkg::DATA_RESET;
      tx_sh_r <= sio_pkg::DATA_RESET;
      tx_empty_r <= 1'b1;
      tx_busy_r <= 1'b0;
      tx_cnt_r <= 4'h0;
      tx_st_r <= ST_IDLE;
      tx_par_r <= 1'b0;
      txd_r <= 1'b1;
      tx_done_ev <= 1'b0;
      sync_busy_r <= 1'b0;
      started_r <= 1'b0;
    end else begin
      tx_done_ev <= 1'b0;
      if (i_mode == sio_pkg::MODE_OFF) begin
        started_r <= 1'b0;
      end
      if (tx_start) begin
        tx_sh_r <= tx_buf_r;
        tx_busy_r <= 1'b1;
        started_r <= 1'b1;
        tx_cnt_r <= 4'h0;
        tx_par_r <= i_parity_odd;
        tx_st_r <= is_async ? ST_START : ST_DATA;
        sync_busy_r <= is_sync;
      end
      if (i_tx_write) begin
        tx_buf_r <= tx_wdata;
        tx_empty_r <= 1'b0;
      end else if (tx_start) begin
        tx_empty_r <= 1'b1;
      end
      if (tx_busy_r && is_async && bit_tick) begin
        case (tx_st_r)
          ST_START: begin
            txd_r <= 1'b0;
            tx_st_r <= ST_DATA;
          end
          ST_DATA: begin
            txd_r <= tx_sh_r[tx_cnt_r];
            tx_par_r <= tx_par_r ^ tx_sh_r[tx_cnt_r];
            tx_cnt_r <= tx_cnt_r + 4'h1;
            if (tx_cnt_r == nbits - 4'h1) begin
              tx_st_r <= i_parity_en ? ST_PARITY : ST_STOP;
              tx_cnt_r <= 4'h0;
            end
          end
          ST_PARITY: begin
            txd_r <= tx_par_r;
            tx_st_r <= ST_STOP;
          end
          ST_STOP: begin
            txd_r <= 1'b1;
            tx_cnt_r <= tx_cnt_r + 4'h1;
            if (tx_cnt_r == {3'h0, i_two_stop}) begin
              tx_st_r <= ST_IDLE;
            end
          end
          default: begin
            txd_r <= 1'b1;
            tx_busy_r <= 1'b0;
            tx_done_ev <= 1'b1;
          end
        endcase
      end
      // Sync shifts buffer data even if receive-only
      if (sync_busy_r && sh_edge) begin
        txd_r <= pick(tx_sh_r, tx_cnt_r, i_msb_first, 4'h8);
        tx_cnt_r <= tx_cnt_r + 4'h1;
      end
      if (sync_busy_r && sm_edge && tx_cnt_r == 4'h8) begin
        sync_busy_r <= 1'b0;
        tx_busy_r <= 1'b0;
        tx_done_ev <= 1'b1;
        txd_r <= 1'b1;
      end
    end
  end

  // Receive side
  logic [3:0] rx_os_r;
  logic rx_done_ev;
  logic [8:0] rx_word;
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      rx_sh_r <= sio_pkg::DATA_RESET;
      rx_cnt_r <= 4'h0;
      rx_st_r <= ST_IDLE;
      rx_par_r <= 1'b0;
      rx_os_r <= 4'h0;
      rx_done_ev <= 1'b0;
      rx_stop2_r <= 1'b0;
      o_framing_err <= 1'b0;
      o_parity_err <= 1'b0;
    end else begin
      rx_done_ev <= 1'b0;
      if (is_async && brg_tick) begin
        rx_os_r <= rx_os_r + 4'h1;
      end
      case (rx_st_r)
        ST_IDLE: begin
          rx_cnt_r <= 4'h0;
          rx_par_r <= i_parity_odd;
          rx_stop2_r <= 1'b0;
          if (is_async && i_rx_enable && !rx_s2_r) begin
            rx_st_r <= ST_START;
            rx_os_r <= 4'h0;
          end
        end
        ST_START: begin
          if (brg_tick && rx_os_r == 4'(sio_pkg::SAMPLE_POINT - 1)) begin
            rx_st_r <= rx_s2_r ? ST_IDLE : ST_DATA;
            rx_os_r <= 4'h0;
          end
        end
        ST_DATA: begin
          if (brg_tick && rx_os_r == 4'(sio_pkg::OVERSAMPLE - 1)) begin
            rx_sh_r[rx_cnt_r] <= rx_s2_r;
            rx_par_r <= rx_par_r ^ rx_s2_r;
            rx_cnt_r <= rx_cnt_r + 4'h1;
            if (rx_cnt_r == nbits - 4'h1) begin
              rx_st_r <= i_parity_en ? ST_PARITY : ST_STOP;
            end
          end
        end
        ST_PARITY: begin
          if (brg_tick && rx_os_r == 4'(sio_pkg::OVERSAMPLE - 1)) begin
            rx_par_r <= rx_par_r ^ rx_s2_r;
            rx_st_r <= ST_STOP;
          end
        end
        ST_STOP: begin
          if (brg_tick && rx_os_r == 4'(sio_pkg::OVERSAMPLE - 1)) begin
            if (!i_two_stop || rx_stop2_r) begin
              rx_st_r <= ST_IDLE;
              rx_done_ev <= 1'b1;
              o_framing_err <= !rx_s2_r || (i_two_stop && !rx_par_r && 1'b0)
                               || o_framing_err && 1'b0;
              o_parity_err <= i_parity_en && rx_par_r;
            end else begin
              rx_stop2_r <= 1'b1;
              if (!rx_s2_r) begin
                o_framing_err <= 1'b1;
              end
            end
          end
        end
        default: rx_st_r <= ST_IDLE;
      endcase
      // Sync receive samples on the opposite edge
      if (sync_busy_r && sm_edge && rx_armed_r) begin
        if (i_msb_first) begin
          rx_sh_r <= {1'b0, rx_sh_r[6:0], rx_s2_r};
        end else begin
          rx_sh_r <= {1'b0, rx_s2_r, rx_sh_r[7:1]};
        end
        if (tx_cnt_r == 4'h8) begin
          rx_done_ev <= 1'b1;
          o_framing_err <= 1'b0;
          o_parity_err <= 1'b0;
        end
      end
    end
  end
  assign rx_word = (is_async && i_char_len == sio_pkg::LEN7)
                   ? {2'h0, rx_sh_r[6:0]}
                   : (is_async && i_char_len == sio_pkg::LEN8)
                   ? {1'b0, rx_sh_r[7:0]} : rx_sh_r;

  // Receive buffer, overrun and interrupts
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      o_rx_data <= sio_pkg::DATA_RESET;
      o_rx_full <= 1'b0;
      o_overrun_err <= 1'b0;
      o_rx_irq <= 1'b0;
      o_tx_irq <= 1'b0;
      o_tx_done <= 1'b0;
      rx_armed_r <= 1'b0;
    end else begin
      o_tx_irq <= i_tx_irq_on_done ? tx_done_ev : tx_load_ev;
      o_tx_done <= tx_done_ev;
      o_rx_irq <= 1'b0;
      if (is_sync && tx_start) begin
        rx_armed_r <= i_rx_enable;
      end else if (rx_done_ev && is_sync) begin
        rx_armed_r <= 1'b0;
      end
      if (rx_done_ev) begin
        o_rx_data <= (CHANNEL == 3 && i_data_invert) ? ~rx_word : rx_word;
        o_rx_full <= 1'b1;
        o_overrun_err <= o_rx_full && !i_rx_read;
        // Overwrite, but hold back the interrupt
        o_rx_irq <= !(o_rx_full && !i_rx_read);
      end else if (i_rx_read) begin
        o_rx_full <= 1'b0;
        if (i_continuous_rx && is_sync) begin
          rx_armed_r <= 1'b1;
        end
      end
    end
  end

  // Pin drivers
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      o_serial_data_out <= 1'b1;
      o_serial_data_oe_n <= 1'b1;
      o_transfer_clock_pin <= 1'b1;
      o_transfer_clock_oe_n <= 1'b1;
      o_alt_clock_pin <= 1'b1;
      o_alt_clock_oe_n <= 1'b1;
      o_handshake_pin <= 1'b1;
      o_handshake_oe_n <= 1'b1;
      o_tx_buffer_empty <= 1'b1;
      o_error_sum <= 1'b0;
      o_config_err <= 1'b0;
    end else begin
      // High or floating until first transfer
      o_serial_data_out <= started_r ? txd_r : 1'b1;
      o_serial_data_oe_n <= (i_mode == sio_pkg::MODE_OFF)
                            || (i_open_drain && (txd_r || !started_r));
      // Output clock only with internal clock
      // Second channel picks one of two clock pins
      o_transfer_clock_pin <= sclk_r;
      o_alt_clock_pin <= sclk_r;
      o_transfer_clock_oe_n <= !(is_sync && !ext_clk
                                 && !(multi_ok
                                      && i_alternate_clock_pin_select));
      o_alt_clock_oe_n <= !(is_sync && !ext_clk && multi_ok
                            && i_alternate_clock_pin_select);
      // Request-to-send low when ready to receive
      o_handshake_pin <= !(i_rx_enable && !o_rx_full);
      o_handshake_oe_n <= !(i_mode != sio_pkg::MODE_OFF
                            && !i_handshake_disable && i_handshake_rts_sel
                            && !multi_ok);
      o_tx_buffer_empty <= tx_empty_r;
      o_error_sum <= o_overrun_err | o_framing_err | o_parity_err;
      o_config_err <= i_multi_clock_en && i_split_handshake_en;
    end
  end
endmodule

/* File: hdl/sio_pkg.sv */
package sio_pkg;
  // Mode select codes
  localparam logic [1:0] MODE_OFF = 2'h0;
  localparam logic [1:0] MODE_SYNC = 2'h1;
  localparam logic [1:0] MODE_ASYNC = 2'h2;
  // Prescaler choices for the internal clock
  localparam logic [1:0] PRE_DIV1 = 2'h0;
  localparam logic [1:0] PRE_DIV8 = 2'h1;
  localparam logic [1:0] PRE_DIV32 = 2'h2;
  localparam int PRE_DIV8_CNT = 8;
  localparam int PRE_DIV32_CNT = 32;
  // Asynchronous bit time is this many divided ticks
  localparam int OVERSAMPLE = 16;
  localparam int SAMPLE_POINT = 8;
  // Character lengths
  localparam logic [1:0] LEN7 = 2'h0;
  localparam logic [1:0] LEN8 = 2'h1;
  localparam logic [1:0] LEN9 = 2'h2;
  // Reset values
  localparam logic [8:0] DATA_RESET = 9'h000;
  localparam logic [7:0] BRG_RESET = 8'h00;
endpackage

/* File: tb/serial_peer.sv */
`timescale 1ns/1ps
module serial_peer (
  input wire logic i_clock,
  input wire logic i_go,
  input wire logic [7:0] i_data,
  input wire logic i_bad_par,
  input wire logic i_bad_stop,
  input wire logic [15:0] i_bit_cycles,
  output logic o_line,
  output logic o_busy
);
  logic [10:0] frame;
  // Line idles high, as a pulled-up idle line would
  initial begin
    o_line = 1'b1;
    o_busy = 1'b0;
  end
  // start, LSB first, even parity, stop
  always @(posedge i_clock) begin
    if (i_go && !o_busy) begin
      frame = {~i_bad_stop, ^i_data ^ i_bad_par, i_data, 1'b0};
      o_busy <= 1'b1;
      for (int k = 0; k < 11; k++) begin
        o_line <= frame[k];
        repeat (i_bit_cycles) @(posedge i_clock);
      end
      o_line <= 1'b1;
      o_busy <= 1'b0;
    end
  end
endmodule

/* File: tb/sio_checker.sv */
`timescale 1ns/1ps
module sio_checker (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_ext_clock_sel,
  input wire logic i_handshake_disable,
  input wire logic i_handshake_rts_sel,
  input wire logic i_handshake_pin,
  input wire logic i_multi_clock_en,
  input wire logic i_split_handshake_en,
  input wire logic i_tx_irq_on_done,
  input wire logic i_tx_enable,
  input wire logic i_tx_write,
  input wire logic o_serial_data_out,
  input wire logic o_serial_data_oe_n,
  input wire logic o_transfer_clock_oe_n,
  input wire logic o_handshake_oe_n,
  input wire logic o_tx_buffer_empty,
  input wire logic o_tx_done,
  input wire logic o_rx_full,
  input wire logic o_tx_irq,
  input wire logic o_rx_irq,
  input wire logic o_overrun_err,
  input wire logic o_framing_err,
  input wire logic o_parity_err,
  input wire logic o_error_sum,
  input wire logic o_config_err
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_rst);
  logic written_r;
  logic hs_in_r;
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      written_r <= 1'b0;
    end else if (i_tx_write) begin
      written_r <= 1'b1;
    end
  end
  // Handshake pin held as input for two edges in a row
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      hs_in_r <= 1'b0;
    end else begin
      hs_in_r <= i_handshake_disable || !i_handshake_rts_sel;
    end
  end
  AST_IDLE_HIGH: assert property (!written_r |->
    o_serial_data_out || o_serial_data_oe_n) else $error("data out not idle");
  AST_CFG_EXCL: assert property (i_multi_clock_en && i_split_handshake_en
    |-> ##[1:2] o_config_err) else $error("config clash not flagged");
  AST_CLK_INPUT: assert property (i_ext_clock_sel && $past(i_ext_clock_sel)
    |-> o_transfer_clock_oe_n) else $error("clock pin driven in ext mode");
  AST_HS_PORT: assert property (hs_in_r &&
    (i_handshake_disable || !i_handshake_rts_sel) |-> o_handshake_oe_n)
    else $error("handshake pin driven");
  AST_TX_GATE: assert property ($rose(o_tx_buffer_empty)
    |-> $past(i_tx_enable)) else $error("load without enable");
  AST_CTS_GATE: assert property ($rose(o_tx_buffer_empty) &&
    !i_handshake_disable && !i_handshake_rts_sel |-> !$past(i_handshake_pin, 2))
    else $error("load while clear-to-send high");
  // Load pulse leads the registered empty flag by one cycle
  AST_TXIRQ_LOAD: assert property ($rose(o_tx_buffer_empty) &&
    !i_tx_irq_on_done |-> $past(o_tx_irq)) else $error("no irq at load");
  AST_TXIRQ_DONE: assert property (o_tx_done && i_tx_irq_on_done
    |-> ##[0:2] o_tx_irq) else $error("no irq at completion");
  AST_RXIRQ_FULL: assert property (o_rx_irq |-> ##[0:1] o_rx_full)
    else $error("rx irq without full buffer");
  AST_OVR_NO_IRQ: assert property ($rose(o_overrun_err)
    |-> !o_rx_irq && !$past(o_rx_irq)) else $error("rx irq on overrun");
  AST_ERR_SUM: assert property (o_overrun_err || o_framing_err ||
    o_parity_err |-> ##[0:1] o_error_sum) else $error("error sum missing");
endmodule
bind serial_io_sync_async_channel sio_checker chk_u (
  .i_clock(i_clock), .i_rst(i_rst), .i_ext_clock_sel(i_ext_clock_sel),
  .i_handshake_disable(i_handshake_disable),
  .i_handshake_rts_sel(i_handshake_rts_sel),
  .i_handshake_pin(i_handshake_pin), .i_multi_clock_en(i_multi_clock_en),
  .i_split_handshake_en(i_split_handshake_en),
  .i_tx_irq_on_done(i_tx_irq_on_done), .i_tx_enable(i_tx_enable),
  .i_tx_write(i_tx_write), .o_serial_data_out(o_serial_data_out),
  .o_serial_data_oe_n(o_serial_data_oe_n),
  .o_transfer_clock_oe_n(o_transfer_clock_oe_n),
  .o_handshake_oe_n(o_handshake_oe_n), .o_tx_buffer_empty(o_tx_buffer_empty),
  .o_tx_done(o_tx_done), .o_rx_full(o_rx_full), .o_tx_irq(o_tx_irq),
  .o_rx_irq(o_rx_irq), .o_overrun_err(o_overrun_err),
  .o_framing_err(o_framing_err), .o_parity_err(o_parity_err),
  .o_error_sum(o_error_sum), .o_config_err(o_config_err)
);

/* File: tb/tb_serial_io_sync_async_channel.sv */
`timescale 1ns/1ps
module tb_serial_io_sync_async_channel;
  localparam int BIT = 32;
  logic i_clock = 1'b0;
  logic i_rst = 1'b1;
  logic link_clock = 1'b0;
  logic [1:0] mode = 2'h0;
  logic [7:0] brg = 8'h01;
  logic ext_sel = 1'b0, od = 1'b0, hs_dis = 1'b1, rts_sel = 1'b0, cts = 1'b1;
  logic multi = 1'b0, split = 1'b0, alt = 1'b0, irq_done = 1'b0;
  logic pol = 1'b0, msb = 1'b0, cont = 1'b0, odd = 1'b0;
  logic tx_en = 1'b0, rx_en = 1'b0, wr = 1'b0, rd = 1'b0;
  logic [8:0] tx_data = 9'h000;
  logic go = 1'b0, bad_par = 1'b0, bad_stop = 1'b0, irq_seen = 1'b0;
  logic [7:0] pdata = 8'h00;
  logic rx_line, pbusy, sdo, sdo_oe_n, clk_oe_n, tx_empty, rx_full, rx_irq;
  logic ovr, fe, pe, esum, cfg_err;
  logic [8:0] rx_data;
  int fails = 0;
  int compares = 0;
  always #2.5 i_clock = ~i_clock;
  // Link clock runs free; only the external-clock selection uses it
  always #3 link_clock = ~link_clock;
  always @(posedge i_clock) if (rx_irq) irq_seen <= 1'b1;
  serial_io_sync_async_channel #(.CHANNEL(1)) dut_u (
    .i_clock(i_clock), .i_rst(i_rst), .i_transfer_clock_pin(link_clock),
    .i_mode(mode), .i_prescale(sio_pkg::PRE_DIV1), .i_ext_clock_sel(ext_sel),
    .i_clock_polarity(pol), .i_msb_first(msb), .i_char_len(sio_pkg::LEN8),
    .i_parity_en(1'b1), .i_parity_odd(odd), .i_two_stop(1'b0), .i_brg(brg),
    .i_handshake_disable(hs_dis), .i_handshake_rts_sel(rts_sel),
    .i_multi_clock_en(multi), .i_alternate_clock_pin_select(alt),
    .i_split_handshake_en(split), .i_open_drain(od), .i_continuous_rx(cont),
    .i_data_invert(1'b0), .i_tx_irq_on_done(irq_done), .i_tx_enable(tx_en),
    .i_rx_enable(rx_en), .i_tx_write(wr), .i_tx_data(tx_data),
    .i_rx_read(rd), .i_serial_data_in(rx_line), .i_handshake_pin(cts),
    .o_serial_data_out(sdo), .o_serial_data_oe_n(sdo_oe_n),
    .o_transfer_clock_pin(), .o_transfer_clock_oe_n(clk_oe_n),
    .o_alt_clock_pin(), .o_alt_clock_oe_n(), .o_handshake_pin(),
    .o_handshake_oe_n(), .o_tx_buffer_empty(tx_empty), .o_tx_done(),
    .o_rx_data(rx_data), .o_rx_full(rx_full), .o_tx_irq(), .o_rx_irq(rx_irq),
    .o_overrun_err(ovr), .o_framing_err(fe), .o_parity_err(pe),
    .o_error_sum(esum), .o_config_err(cfg_err)
  );
  serial_peer peer_u (
    .i_clock(i_clock), .i_go(go), .i_data(pdata), .i_bad_par(bad_par),
    .i_bad_stop(bad_stop), .i_bit_cycles(16'(BIT)), .o_line(rx_line),
    .o_busy(pbusy)
  );
  task automatic check(input logic [8:0] seen, input logic [8:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic test_done();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic pulse_write(input logic [8:0] d);
    tx_data <= d;
    wr <= 1'b1;
    @(posedge i_clock) wr <= 1'b0;
  endtask
  task automatic read_buf();
    rd <= 1'b1;
    @(posedge i_clock) rd <= 1'b0;
  endtask
  task automatic send(input logic [7:0] d, input logic bp, input logic bs);
    pdata <= d;
    bad_par <= bp;
    bad_stop <= bs;
    go <= 1'b1;
    irq_seen <= 1'b0;
    @(posedge i_clock) go <= 1'b0;
    @(posedge i_clock);
    while (pbusy) @(posedge i_clock);
    repeat (4) @(posedge i_clock);
  endtask
  task automatic test_idle();
    mode <= sio_pkg::MODE_ASYNC;
    repeat (4) @(posedge i_clock);
    check(9'(sdo), 9'h001);
    od <= 1'b1;
    repeat (4) @(posedge i_clock);
    check(9'(sdo_oe_n), 9'h001);
    od <= 1'b0;
    $display("test_idle done");
  endtask
  task automatic test_tx();
    int k;
    logic [10:0] exp_f;
    exp_f = {1'b1, ^8'ha5, 8'ha5, 1'b0};
    tx_en <= 1'b1;
    pulse_write(9'h0a5);
    k = 0;
    while (sdo !== 1'b0 && k < 400) begin
      @(posedge i_clock);
      k++;
    end
    repeat (BIT / 2) @(posedge i_clock);
    for (int b = 0; b < 11; b++) begin
      check(9'(sdo), 9'(exp_f[b]));
      repeat (BIT) @(posedge i_clock);
    end
    $display("test_tx done");
  endtask
  task automatic test_cts();
    hs_dis <= 1'b0;
    irq_done <= 1'b1;
    pulse_write(9'h03c);
    repeat (200) @(posedge i_clock);
    check(9'(tx_empty), 9'h000);
    check(9'(sdo), 9'h001);
    cts <= 1'b0;
    repeat (20) @(posedge i_clock);
    check(9'(tx_empty), 9'h001);
    repeat (12 * BIT) @(posedge i_clock);
    hs_dis <= 1'b1;
    irq_done <= 1'b0;
    $display("test_cts done");
  endtask
  task automatic test_rx();
    send(8'h55, 1'b0, 1'b0);
    check(9'(irq_seen), 9'h000);
    check(9'(rx_full), 9'h000);
    rx_en <= 1'b1;
    send(8'h3c, 1'b0, 1'b0);
    check(rx_data, 9'h03c);
    check(9'(irq_seen), 9'h001);
    check(9'(esum), 9'h000);
    send(8'hc3, 1'b0, 1'b0);
    check(rx_data, 9'h0c3);
    check(9'(ovr), 9'h001);
    check(9'(irq_seen), 9'h000);
    check(9'(esum), 9'h001);
    read_buf();
    send(8'h81, 1'b0, 1'b1);
    check(9'(fe), 9'h001);
    check(9'(ovr), 9'h000);
    read_buf();
    send(8'h81, 1'b1, 1'b0);
    check(9'(pe), 9'h001);
    check(9'(fe), 9'h000);
    check(9'(esum), 9'h001);
    read_buf();
    $display("test_rx done");
  endtask
  task automatic test_sync();
    mode <= sio_pkg::MODE_SYNC;
    pol <= 1'b1;
    msb <= 1'b1;
    cont <= 1'b1;
    pulse_write(9'h000);
    repeat (10) @(posedge i_clock);
    check(9'(clk_oe_n), 9'h000);
    repeat (200) @(posedge i_clock);
    ext_sel <= 1'b1;
    repeat (4) @(posedge i_clock);
    check(9'(clk_oe_n), 9'h001);
    multi <= 1'b1;
    alt <= 1'b1;
    split <= 1'b1;
    repeat (4) @(posedge i_clock);
    check(9'(cfg_err), 9'h001);
    $display("test_sync done");
  endtask
  initial begin
    repeat (6) @(posedge i_clock);
    i_rst <= 1'b0;
    repeat (2) @(posedge i_clock);
    test_idle();
    test_tx();
    test_cts();
    test_rx();
    test_sync();
    test_done();
  end
  // Whole run needs about 3000 cycles; give generous margin
  initial begin
    #100us;
    fails++;
    test_done();
  end
endmodule
